// ### rtl/cbd_branch_decode.sv
// program counter sequencing for the in-page conditional jumps
`timescale 1ns/1ps
module cbd_branch_decode (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic fetch_valid_in,
	input wire logic [cbd_pkg::BYTE_W-1:0] fetch_byte_in,
	input wire cbd_pkg::cbd_cond_t cond_in,
	output logic [cbd_pkg::PC_W-1:0] pc_out,
	output logic addr_phase_out,
	output logic branch_done_out,
	output logic branch_taken_out,
	output logic other_op_out,
	output logic [cbd_pkg::BYTE_W-1:0] other_byte_out
);
	import cbd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state

	cbd_state_t state;
	cbd_state_t next_state;
	cbd_kind_t kind_q;
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] next_pc;
	logic taken;

	////////////////////////////////////////////////////////////////////////////
	// decode and selection

	wire in_opcode = (state == ST_OPCODE);
	wire in_address = (state == ST_ADDRESS);
	wire cbd_kind_t op_kind = cbd_decode(fetch_byte_in);
	wire op_is_branch = (op_kind != K_NONE);
	wire take_opcode = in_opcode & fetch_valid_in;
	wire take_addr = in_address & fetch_valid_in;
	wire start_branch = take_opcode & op_is_branch;
	wire start_other = take_opcode & ~op_is_branch;

	cbd_cond_eval u_cond_eval (
		.kind_in(kind_q),
		.cond_in(cond_in),
		.taken_out(taken)
	);

	// only the low byte is replaced so the target stays on this page
	wire [PC_W-1:0] pc_target = {pc[PC_W-1:PAGE_LSB], fetch_byte_in};
	// pc already points past the opcode, one more step skips the address byte
	wire [PC_W-1:0] pc_inc = pc + PC_STEP;

	always_comb begin
		next_pc = pc;
		next_state = state;
		unique case (state)
			ST_OPCODE: begin
				if (fetch_valid_in) begin
					next_pc = pc_inc;
					if (op_is_branch) begin
						next_state = ST_ADDRESS;
					end
				end
			end
			ST_ADDRESS: begin
				if (fetch_valid_in) begin
					next_state = ST_OPCODE;
					if (taken) begin
						next_pc = pc_target;
					end else begin
						next_pc = pc_inc;
					end
				end
			end
			default: begin
				next_state = ST_OPCODE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			state <= ST_OPCODE;
			pc <= PC_RESET;
		end else begin
			state <= next_state;
			pc <= next_pc;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			kind_q <= K_NONE;
		end else if (start_branch) begin
			kind_q <= op_kind;
		end
	end

	// status pulses are registered so every output comes from a flop
	always_ff @(posedge ref_clk_in) begin
		if (!rst_b_in) begin
			branch_done_out <= 1'b0;
			branch_taken_out <= 1'b0;
			other_op_out <= 1'b0;
			other_byte_out <= BYTE_ZERO;
		end else begin
			branch_done_out <= take_addr;
			branch_taken_out <= take_addr & taken;
			other_op_out <= start_other;
			if (start_other) begin
				other_byte_out <= fetch_byte_in;
			end
		end
	end

	assign pc_out = pc;
	assign addr_phase_out = state[1];

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	sequence s_opcode(logic [BYTE_W-1:0] op);
		in_opcode && fetch_valid_in && fetch_byte_in == op;
	endsequence

	sequence s_addr_taken(logic cond);
		fetch_valid_in && cond;
	endsequence

	property p_test_zero_low;
		s_opcode(OP_JUMP_IF_TEST_ZERO_LOW) ##1 s_addr_taken(!cond_in.test_input_zero)
			|=> pc == {$past(pc[PC_W-1:PAGE_LSB]), $past(fetch_byte_in)};
	endproperty
	a_test_zero_low: assert property (p_test_zero_low)
		else $error("test zero low jump missed its target");

	property p_test_zero_high;
		s_opcode(OP_JUMP_IF_TEST_ZERO_LOW) ##1 s_addr_taken(cond_in.test_input_zero)
			|=> pc == $past(pc, 2) + PC_SKIP;
	endproperty
	a_test_zero_high: assert property (p_test_zero_high)
		else $error("test zero high did not skip two bytes");

	property p_test_one;
		s_opcode(OP_JUMP_IF_TEST_ONE_LOW) ##1 fetch_valid_in
			|=> pc == ($past(cond_in.test_input_one) ? $past(pc, 2) + PC_SKIP
				: {$past(pc[PC_W-1:PAGE_LSB]), $past(fetch_byte_in)});
	endproperty
	a_test_one: assert property (p_test_one)
		else $error("test one jump went to the wrong address");

	property p_acc_nonzero;
		s_opcode(OP_JUMP_IF_ACC_NONZERO) ##1 s_addr_taken(cond_in.acc != BYTE_ZERO)
			|=> branch_taken_out && pc[BYTE_W-1:0] == $past(fetch_byte_in);
	endproperty
	a_acc_nonzero: assert property (p_acc_nonzero)
		else $error("nonzero accumulator did not jump");

	property p_acc_zero;
		s_opcode(OP_JUMP_IF_ACC_NONZERO) ##1 s_addr_taken(cond_in.acc == BYTE_ZERO)
			|=> !branch_taken_out && pc == $past(pc, 2) + PC_SKIP;
	endproperty
	a_acc_zero: assert property (p_acc_zero)
		else $error("zero accumulator did not skip two bytes");

	property p_timer;
		s_opcode(OP_JUMP_IF_TIMER_OVERFLOW) ##1 fetch_valid_in
			|=> branch_done_out && branch_taken_out == $past(cond_in.timer_overflow_flag);
	endproperty
	a_timer: assert property (p_timer)
		else $error("timer flag jump decision wrong");

	property p_pc_wrap;
		start_other && pc == PC_TOP |=> pc == PC_RESET;
	endproperty
	a_pc_wrap: assert property (p_pc_wrap)
		else $error("program counter does not wrap at twelve bits");

	property p_same_page;
		take_addr && taken |=> pc[PC_W-1:PAGE_LSB] == $past(pc[PC_W-1:PAGE_LSB]);
	endproperty
	a_same_page: assert property (p_same_page)
		else $error("taken jump left the current page");

	// a new opcode may follow the address byte at once, so only the next cycle is checked
	property p_two_cycles;
		start_branch ##1 fetch_valid_in |=> branch_done_out && in_opcode;
	endproperty
	a_two_cycles: assert property (p_two_cycles)
		else $error("branch did not finish after its second byte");

	sequence s_addr_byte;
		in_address && fetch_valid_in;
	endsequence

	// a stalled branch keeps waiting for its second byte with the counter frozen
	property p_stall_hold;
		in_address && !fetch_valid_in |=> in_address && $stable(pc);
	endproperty
	a_stall_hold: assert property (p_stall_hold)
		else $error("stalled branch moved before its address byte");

	// holds after any stall, where the fixed-spacing checks above stay silent
	property p_addr_result;
		s_addr_byte |=> branch_done_out && (branch_taken_out
			? pc[BYTE_W-1:0] == $past(fetch_byte_in) : pc == $past(pc) + PC_STEP);
	endproperty
	a_addr_result: assert property (p_addr_result)
		else $error("second byte did not settle the counter");

	property p_other_step;
		start_other |=> other_op_out && !branch_done_out && pc == $past(pc) + PC_STEP;
	endproperty
	a_other_step: assert property (p_other_step)
		else $error("single byte opcode did not step the counter by one");

	property p_no_false_done;
		!take_addr |=> !branch_done_out && !branch_taken_out;
	endproperty
	a_no_false_done: assert property (p_no_false_done)
		else $error("branch reported without its address byte");

endmodule

// ### rtl/cbd_pkg.sv
// constants, types and decode function for the conditional branch decoder
package cbd_pkg;

	localparam int PC_W = 12;
	localparam int BYTE_W = 8;
	localparam int PAGE_LSB = 8;

	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [PC_W-1:0] PC_STEP = 12'h001;
	localparam logic [PC_W-1:0] PC_SKIP = 12'h002;
	localparam logic [PC_W-1:0] PC_TOP = 12'hFFF;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

	localparam logic [BYTE_W-1:0] OP_JUMP_IF_TEST_ZERO_LOW = 8'h26;
	localparam logic [BYTE_W-1:0] OP_JUMP_IF_TEST_ONE_LOW = 8'h46;
	localparam logic [BYTE_W-1:0] OP_JUMP_IF_ACC_NONZERO = 8'h96;
	localparam logic [BYTE_W-1:0] OP_JUMP_IF_TIMER_OVERFLOW = 8'h16;

	typedef enum logic [4:0] {
		K_NONE = 5'b00001,
		K_TEST_ZERO = 5'b00010,
		K_TEST_ONE = 5'b00100,
		K_ACC = 5'b01000,
		K_TIMER = 5'b10000
	} cbd_kind_t;

	typedef enum logic [1:0] {
		ST_OPCODE = 2'b01,
		ST_ADDRESS = 2'b10
	} cbd_state_t;

	// condition sources, sampled while the address byte is accepted
	typedef struct packed {
		logic test_input_zero;
		logic test_input_one;
		logic [BYTE_W-1:0] acc;
		logic timer_overflow_flag;
	} cbd_cond_t;

	function automatic cbd_kind_t cbd_decode(input logic [BYTE_W-1:0] op);
		cbd_kind_t k;
		k = K_NONE;
		unique case (op)
			OP_JUMP_IF_TEST_ZERO_LOW: k = K_TEST_ZERO;
			OP_JUMP_IF_TEST_ONE_LOW: k = K_TEST_ONE;
			OP_JUMP_IF_ACC_NONZERO: k = K_ACC;
			OP_JUMP_IF_TIMER_OVERFLOW: k = K_TIMER;
			default: k = K_NONE;
		endcase
		return k;
	endfunction

endpackage

// ### rtl/cbd_cond_eval.sv
// condition evaluator for the four in-page conditional jumps
`timescale 1ns/1ps
module cbd_cond_eval (
	input wire cbd_pkg::cbd_kind_t kind_in,
	input wire cbd_pkg::cbd_cond_t cond_in,
	output logic taken_out
);
	import cbd_pkg::*;

	wire test_zero_low = ~cond_in.test_input_zero;
	wire test_one_low = ~cond_in.test_input_one;
	wire acc_nonzero = (cond_in.acc != BYTE_ZERO);
	wire timer_set = cond_in.timer_overflow_flag;

	// a non-branch kind never reports taken
	assign taken_out = ((kind_in == K_TEST_ZERO) & test_zero_low) |
		((kind_in == K_TEST_ONE) & test_one_low) |
		((kind_in == K_ACC) & acc_nonzero) |
		((kind_in == K_TIMER) & timer_set);

endmodule

// ### testbench/cbd_branch_decode_bench.sv
// self-checking bench for the in-page conditional branch decoder
`timescale 1ns/1ps
module cbd_branch_decode_bench;
	import cbd_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic fetch_valid_in = 1'b0;
	logic [BYTE_W-1:0] fetch_byte_in = 8'h00;
	cbd_cond_t cond_in = '0;
	logic [PC_W-1:0] pc_out;
	logic addr_phase_out;
	logic branch_done_out;
	logic branch_taken_out;
	logic other_op_out;
	logic [BYTE_W-1:0] other_byte_out;
	logic [PC_W-1:0] exp_pc = 12'h000;
	int bad_count = 0;
	int comparisons = 0;
	logic [BYTE_W-1:0] ops [4] = '{OP_JUMP_IF_TEST_ZERO_LOW, OP_JUMP_IF_TEST_ONE_LOW,
		OP_JUMP_IF_ACC_NONZERO, OP_JUMP_IF_TIMER_OVERFLOW};

	always #5 ref_clk_in = ~ref_clk_in;

	cbd_branch_decode i_cbd_branch_decode (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.fetch_valid_in(fetch_valid_in),
		.fetch_byte_in(fetch_byte_in),
		.cond_in(cond_in),
		.pc_out(pc_out),
		.addr_phase_out(addr_phase_out),
		.branch_done_out(branch_done_out),
		.branch_taken_out(branch_taken_out),
		.other_op_out(other_op_out),
		.other_byte_out(other_byte_out)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic cmp_val(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// offers one byte at the next rising edge and leaves it valid, so bytes can chain
	task automatic feed(input logic [BYTE_W-1:0] b);
		fetch_valid_in = 1'b1;
		fetch_byte_in = b;
		@(negedge ref_clk_in);
	endtask

	// drops valid for n edges; the caller may raise it again in this same time step
	task automatic idle(input int n);
		fetch_valid_in = 1'b0;
		repeat (n) @(negedge ref_clk_in);
	endtask

	// all other sources are set so they would not trigger any other jump
	function automatic cbd_cond_t mk(input int i, input logic t);
		cbd_cond_t c;
		c = '{test_input_zero: 1'b1, test_input_one: 1'b1, acc: 8'h00, timer_overflow_flag: 1'b0};
		case (i)
			0: c.test_input_zero = ~t;
			1: c.test_input_one = ~t;
			2: c.acc = t ? 8'h03 : 8'h00;
			default: c.timer_overflow_flag = t;
		endcase
		return c;
	endfunction

	task automatic do_branch(input int i, input logic [BYTE_W-1:0] a, input logic t, input int stall);
		logic [PC_W-1:0] p1;
		// opposite condition during the opcode: only the address-byte sample counts
		cond_in = mk(i, ~t);
		feed(ops[i]);
		p1 = exp_pc + PC_STEP;
		// no stall means the address byte follows on the very next edge
		if (stall > 0) begin
			idle(stall);
		end
		cmp_bit(addr_phase_out, 1'b1);
		cmp_bit(branch_done_out, 1'b0);
		cmp_val(pc_out, p1);
		cond_in = mk(i, t);
		feed(a);
		exp_pc = t ? {p1[PC_W-1:PAGE_LSB], a} : exp_pc + PC_SKIP;
		cmp_val(pc_out, exp_pc);
		cmp_bit(branch_done_out, 1'b1);
		cmp_bit(branch_taken_out, t);
		cmp_bit(addr_phase_out, 1'b0);
		idle(1);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_other;
		feed(8'hA5);
		exp_pc = exp_pc + PC_STEP;
		cmp_val(pc_out, exp_pc);
		cmp_bit(other_op_out, 1'b1);
		cmp_bit(branch_done_out, 1'b0);
		cmp_val({4'h0, other_byte_out}, 12'h0A5);
		idle(1);
	endtask

	task automatic t_all;
		for (int i = 0; i < 4; i++) begin
			do_branch(i, 8'h41 + 8'(i * 16), 1'b1, (i == 1) ? 3 : 0);
			do_branch(i, 8'h9C, 1'b0, 0);
		end
	endtask

	// branch whose address byte sits on the next page: target lands there
	task automatic t_page;
		do_branch(3, 8'hFF, 1'b1, 0);
		do_branch(2, 8'h20, 1'b1, 0);
		cmp_val(pc_out, 12'h120);
		@(negedge ref_clk_in);
		cmp_bit(branch_done_out, 1'b0);
	endtask

	// reset between opcode and address byte drops the pending branch
	task automatic t_reset_mid;
		feed(OP_JUMP_IF_TEST_ONE_LOW);
		fetch_valid_in = 1'b0;
		rst_b_in = 1'b0;
		@(negedge ref_clk_in);
		rst_b_in = 1'b1;
		cmp_val(pc_out, PC_RESET);
		cmp_bit(addr_phase_out, 1'b0);
		exp_pc = PC_RESET;
		t_other();
	endtask

	// a long run of single-byte opcodes carries the counter through FFFh back to 000h
	task automatic t_wrap;
		fetch_byte_in = 8'h00;
		fetch_valid_in = 1'b1;
		repeat (int'(PC_TOP - exp_pc)) @(negedge ref_clk_in);
		cmp_val(pc_out, PC_TOP);
		@(negedge ref_clk_in);
		cmp_val(pc_out, 12'h000);
		cmp_bit(other_op_out, 1'b1);
		idle(1);
		exp_pc = 12'h000;
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge ref_clk_in);
		cmp_val(pc_out, PC_RESET);
		cmp_bit(addr_phase_out, 1'b0);
		cmp_bit(other_op_out, 1'b0);
		rst_b_in = 1'b1;
		t_other();
		t_all();
		t_page();
		t_reset_mid();
		t_wrap();
		wrap_up();
	end
endmodule
